// file: sim/dsos_host_model.sv
// Host controller model that writes the host-forced output levels.
`timescale 1ns/1ps
module dsos_host_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Requested levels: bit 0 output a, bit 1 output b, bit 2 relay.
   input wire logic [2:0] host_word,
   // Host-written levels.
   output logic host_col_a,
   output logic host_col_b,
   output logic host_relay
);
   // A serial write lands one clock later, so the bench never sees an instant change.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) {host_relay, host_col_b, host_col_a} <= 3'h0;
      else {host_relay, host_col_b, host_col_a} <= host_word;
   end
endmodule : dsos_host_model

// file: sim/dsos_top_tb_top.sv
// Self-checking testbench for the drive status output select block.
`timescale 1ns/1ps
module dsos_top_tb_top;
   import dsos_pkg::*;
   localparam int unsigned PLC = 10;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic [SEL_W-1:0] sel_col_a = '0, sel_col_b = '0, sel_relay = '0;
   logic drive_running = 1'h0, fault_any = 1'h0, external_fault_trip = 1'h0;
   logic bus_voltage_low = 1'h0, stop_cmd_active = 1'h0, plc_stage_done = 1'h0;
   logic plc_cycle_done = 1'h0, two_wire_mode = 1'h0, lockout_stop_evt = 1'h0;
   logic preset_count_hit = 1'h0, spec_count_hit = 1'h0;
   logic [FREQ_W-1:0] out_freq = '0, preset_freq = '0, upper_limit = 16'hEA60;
   logic [FREQ_W-1:0] lower_limit = '0, far_band = 16'h00FA, freq_threshold_one_level = 16'h1388;
   logic [FREQ_W-1:0] freq_threshold_one_lag = 16'h0064, freq_threshold_two_level = 16'h09C4, freq_threshold_two_lag = 16'h0064;
   logic [MEAS_W-1:0] out_current = '0, overload_level = 16'hFFFF;
   logic [15:0] overload_ms = '0, run_time_total = '0, run_time_preset = 16'h0010;
   logic [15:0] updn_rate = 16'h0064, max_pulse_hz = '0;
   logic [1:0] freq_increment_decrement_inputs = '0, direction_run_inputs = '0;
   logic [MEAS_N-1:0][MEAS_W-1:0] meas = '0;
   logic [ASEL_W-1:0] sel_ao_a = '0, sel_ao_b = '0, sel_pulse = '0;
   logic [2:0] host_word = '0;
   logic host_col_a, host_col_b, host_relay, collector_output_a, collector_output_b;
   logic relay_output, power_off_display, pulse_output, run_request, run_reverse;
   logic [MEAS_W-1:0] analog_output_a, analog_output_b;
   logic [FREQ_W-1:0] ref_freq;
   int fails = 0;
   int checks = 0;
   int n;
   int m;
   dsos_top #(.PLC_CYC(PLC), .MS_TICK_CYC(5), .RATE_DIV(100)) dut (.*);
   dsos_host_model host (.*);
   // Free-running system clock at 25 MHz.
   always #20 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   // Inputs always move 1 ns after a rising edge so no race with the design.
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Same function on all three outputs; three cycles cover the two-cycle flags.
   task automatic sel3(input logic [SEL_W-1:0] s, input logic e);
      sel_col_a = s;
      sel_col_b = s;
      sel_relay = s;
      step(3);
      chk("col_a", e, collector_output_a);
      chk("col_b", e, collector_output_b);
      chk("relay", e, relay_output);
   endtask : sel3
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the roughly 775 cycles the tests take.
   initial begin
      #(40 * 10000);
      fails++;
      report_and_stop();
   end
   // Main sequence.
   initial begin
      step(10);
      resetn = 1'h1;
      step(2);
      drive_running = 1'h1;
      sel3(SEL_RUN, 1'h1);
      sel3(SEL_ZERO, 1'h1);
      sel3(SEL_RDY, 1'h1);
      stop_cmd_active = 1'h1;
      sel3(SEL_RDY, 1'h0);
      stop_cmd_active = 1'h0;
      preset_count_hit = 1'h1;
      spec_count_hit = 1'h1;
      sel3(SEL_PCNT, 1'h1);
      sel3(SEL_SCNT, 1'h1);
      sel3(5'h12, 1'h0);
      sel3(SEL_TIME, 1'h0);
      run_time_total = 16'h0010;
      sel3(SEL_TIME, 1'h1);
      bus_voltage_low = 1'h1;
      sel3(SEL_UVLO, 1'h1);
      chk("display", 1'h1, power_off_display);
      sel3(SEL_RDY, 1'h0);
      fault_any = 1'h1;
      external_fault_trip = 1'h1;
      sel3(SEL_FAIL, 1'h1);
      sel3(SEL_EXTF, 1'h1);
      external_fault_trip = 1'h0;
      sel3(SEL_EXTF, 1'h0);
      host_word = 3'h7;
      sel3(SEL_HOST, 1'h1);
      host_word = 3'h0;
      sel3(SEL_HOST, 1'h0);
      fault_any = 1'h0;
      bus_voltage_low = 1'h0;
      $display("Status function test done");
      // Band edges: 30 Hz preset, 2.5 Hz band; level 50 Hz, lag 1 Hz.
      preset_freq = 16'h0BB8;
      out_freq = 16'h0ABE;
      sel3(SEL_FAR, 1'h1);
      out_freq = 16'h0ABD;
      sel3(SEL_FAR, 1'h0);
      out_freq = 16'h1388;
      sel3(SEL_FREQ_THRESHOLD_ONE, 1'h1);
      out_freq = 16'h1356;
      sel3(SEL_FREQ_THRESHOLD_ONE, 1'h1);
      out_freq = 16'h1323;
      sel3(SEL_FREQ_THRESHOLD_ONE, 1'h0);
      sel3(SEL_FREQ_THRESHOLD_TWO, 1'h1);
      out_freq = 16'h095F;
      sel3(SEL_FREQ_THRESHOLD_TWO, 1'h0);
      // A 2 ms set time is 10 cycles at the bench tick; the flag must wait past it.
      overload_level = 16'h0100;
      overload_ms = 16'h0002;
      out_current = 16'h0200;
      sel3(SEL_OVLD, 1'h0);
      step(6);
      chk("ovld_early", 1'h0, collector_output_a);
      step(10);
      chk("ovld_late", 1'h1, collector_output_a);
      out_current = '0;
      sel3(SEL_OVLD, 1'h0);
      // Limit flags: preset beyond a limit and output sitting on it.
      preset_freq = 16'hEA61;
      out_freq = 16'hEA60;
      sel3(SEL_FHI, 1'h1);
      out_freq = 16'hEA5F;
      sel3(SEL_FHI, 1'h0);
      lower_limit = 16'h0064;
      preset_freq = '0;
      out_freq = 16'h0064;
      sel3(SEL_FLO, 1'h1);
      preset_freq = 16'h0064;
      sel3(SEL_FLO, 1'h0);
      $display("Frequency flag test done");
      // PLC stage and cycle pulses counted together.
      sel_col_a = SEL_STAGE;
      sel_col_b = SEL_CYCLE;
      plc_stage_done = 1'h1;
      plc_cycle_done = 1'h1;
      step(1);
      plc_stage_done = 1'h0;
      plc_cycle_done = 1'h0;
      n = 0;
      m = 0;
      repeat (PLC + 6) begin
         step(1);
         n += collector_output_a;
         m += collector_output_b;
      end
      chk("stage_pulse", 16'(PLC), 16'(n));
      chk("cycle_pulse", 16'(PLC), 16'(m));
      $display("PLC pulse test done");
      // Two-wire interlock; the bench re-asserts direction as the operator would.
      two_wire_mode = 1'h1;
      direction_run_inputs = 2'h1;
      step(3);
      chk("run", 1'h1, run_request);
      lockout_stop_evt = 1'h1;
      step(1);
      lockout_stop_evt = 1'h0;
      step(3);
      chk("run_locked", 1'h0, run_request);
      direction_run_inputs = 2'h0;
      step(2);
      direction_run_inputs = 2'h2;
      step(3);
      chk("run_again", 1'h1, run_request);
      chk("reverse", 1'h1, run_reverse);
      fault_any = 1'h1;
      step(3);
      chk("run_fault", 1'h0, run_request);
      fault_any = 1'h0;
      step(3);
      chk("run_cleared", 1'h1, run_request);
      $display("Interlock test done");
      // Analog select and ramp: rate equals the divider, so one step a cycle.
      meas[11] = 16'hFFFF;
      meas[3] = 16'h1234;
      sel_ao_a = 4'hB;
      sel_ao_b = 4'h3;
      freq_increment_decrement_inputs = 2'h1;
      step(5);
      chk("ao_a", 16'hFFFF, analog_output_a);
      chk("ao_b", 16'h1234, analog_output_b);
      n = ref_freq;
      step(20);
      chk("ramp", 16'(n + 20), ref_freq);
      // Full scale at 50 kHz gives a 250-cycle half period: two edges in 600 cycles.
      sel_pulse = 4'hB;
      max_pulse_hz = 16'hC350;
      n = 0;
      m = pulse_output;
      repeat (600) begin
         step(1);
         n += (pulse_output != m);
         m = pulse_output;
      end
      chk("pulse_edges", 16'h0002, 16'(n));
      $display("Analog and ramp test done");
      report_and_stop();
   end
endmodule : dsos_top_tb_top

// file: verilog/dsos_cmp_if.sv
// Interface carrying one frequency threshold comparison.
`timescale 1ns/1ps
interface dsos_cmp_if #(parameter int FW = 16);
   logic [FW-1:0] freq;
   logic [FW-1:0] level;
   logic [FW-1:0] lag;
   logic hit;
   modport src (output freq, output level, output lag, input hit);
   modport cmp (input freq, input level, input lag, output hit);
endinterface : dsos_cmp_if

// file: verilog/dsos_hyst.sv
// Hysteretic frequency threshold detector.
`timescale 1ns/1ps
module dsos_hyst (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Comparison.
   dsos_cmp_if.cmp c
);
   logic hit_r;
   logic [$bits(c.freq)-1:0] low;

   // Release point never wraps below zero when the lag exceeds the level.
   assign low = (c.lag > c.level) ? '0 : c.level - c.lag;
   assign c.hit = hit_r;

   // Sets on reaching the level, clears only below level minus lag.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hit_r <= 1'b0;
      end else if (c.freq >= c.level) begin
         hit_r <= 1'b1;
      end else if (c.freq < low) begin
         hit_r <= 1'b0;
      end
   end

   hyst_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (hit_r && c.freq >= low) |=> hit_r) else $error("threshold dropped inside lag");
   hyst_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (c.freq >= c.level) |=> hit_r) else $error("threshold not set at level");
endmodule : dsos_hyst

// file: verilog/dsos_pkg.sv
// Shared constants for the drive status output select block.
package dsos_pkg;
   // Clock rate and derived timing.
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
   localparam int unsigned PLC_PULSE_MS = 500;
   localparam int unsigned PLC_PULSE_CYC = MS_CYC * PLC_PULSE_MS;
   // Pulse output toggles when the phase passes half of full scale times the clock rate.
   localparam longint unsigned PULSE_HALF = 64'h8000 * CLK_HZ;
   // Widths.
   localparam int FREQ_W = 16;
   localparam int MEAS_W = 16;
   localparam int SEL_W = 5;
   localparam int ASEL_W = 4;
   localparam int MEAS_N = 12;
   // Status output selector codes.
   localparam logic [SEL_W-1:0] SEL_RUN = 5'h00;
   localparam logic [SEL_W-1:0] SEL_FAR = 5'h01;
   localparam logic [SEL_W-1:0] SEL_FREQ_THRESHOLD_ONE = 5'h02;
   localparam logic [SEL_W-1:0] SEL_FREQ_THRESHOLD_TWO = 5'h03;
   localparam logic [SEL_W-1:0] SEL_OVLD = 5'h04;
   localparam logic [SEL_W-1:0] SEL_UVLO = 5'h05;
   localparam logic [SEL_W-1:0] SEL_EXTF = 5'h06;
   localparam logic [SEL_W-1:0] SEL_FHI = 5'h07;
   localparam logic [SEL_W-1:0] SEL_FLO = 5'h08;
   localparam logic [SEL_W-1:0] SEL_ZERO = 5'h09;
   localparam logic [SEL_W-1:0] SEL_STAGE = 5'h0A;
   localparam logic [SEL_W-1:0] SEL_CYCLE = 5'h0B;
   localparam logic [SEL_W-1:0] SEL_PCNT = 5'h0C;
   localparam logic [SEL_W-1:0] SEL_SCNT = 5'h0D;
   localparam logic [SEL_W-1:0] SEL_TIME = 5'h0E;
   localparam logic [SEL_W-1:0] SEL_RDY = 5'h0F;
   localparam logic [SEL_W-1:0] SEL_FAIL = 5'h10;
   localparam logic [SEL_W-1:0] SEL_HOST = 5'h11;
   localparam logic [ASEL_W-1:0] ASEL_MAX = 4'hB;
   // Up/down input bit positions.
   localparam int UD_UP = 0;
   localparam int UD_DN = 1;
endpackage : dsos_pkg

// file: verilog/dsos_pulse.sv
// Fixed-width pulse generator restarted by each event.
`timescale 1ns/1ps
module dsos_pulse #(
   parameter int unsigned CYC = 12_500_000
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Event in, pulse out.
   input wire logic ev,
   output logic pulse
);
   localparam int CW = $clog2(CYC + 1);
   logic [CW-1:0] cnt_r;

   if (CYC < 1) begin : g_chk
      $error("pulse width must be at least one cycle");
   end

   // Counts down the pulse width; a new event restarts the full width.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (ev) begin
         cnt_r <= CW'(CYC);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign pulse = (cnt_r != '0);

   pulse_start_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(pulse) |-> $past(ev)) else $error("pulse began without event");
   pulse_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ev |=> pulse [*1] ##0 (cnt_r == CW'(CYC))) else $error("pulse width wrong");
endmodule : dsos_pulse

// file: verilog/dsos_top.sv
// Drive status output select: digital, analog and pulse outputs.
`timescale 1ns/1ps
module dsos_top
   import dsos_pkg::*;
#(
   parameter int unsigned PLC_CYC = PLC_PULSE_CYC,
   parameter int unsigned MS_TICK_CYC = MS_CYC,
   parameter int unsigned RATE_DIV = CLK_HZ
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Status output selectors and host levels.
   input wire logic [SEL_W-1:0] sel_col_a,
   input wire logic [SEL_W-1:0] sel_col_b,
   input wire logic [SEL_W-1:0] sel_relay,
   input wire logic host_col_a,
   input wire logic host_col_b,
   input wire logic host_relay,
   // Drive state.
   input wire logic drive_running,
   input wire logic fault_any,
   input wire logic external_fault_trip,
   input wire logic bus_voltage_low,
   input wire logic stop_cmd_active,
   // Frequencies in 0.01 Hz units.
   input wire logic [FREQ_W-1:0] out_freq,
   input wire logic [FREQ_W-1:0] preset_freq,
   input wire logic [FREQ_W-1:0] upper_limit,
   input wire logic [FREQ_W-1:0] lower_limit,
   input wire logic [FREQ_W-1:0] far_band,
   input wire logic [FREQ_W-1:0] freq_threshold_one_level,
   input wire logic [FREQ_W-1:0] freq_threshold_one_lag,
   input wire logic [FREQ_W-1:0] freq_threshold_two_level,
   input wire logic [FREQ_W-1:0] freq_threshold_two_lag,
   // Overload detection.
   input wire logic [MEAS_W-1:0] out_current,
   input wire logic [MEAS_W-1:0] overload_level,
   input wire logic [15:0] overload_ms,
   // PLC, counter and run time events.
   input wire logic plc_stage_done,
   input wire logic plc_cycle_done,
   input wire logic preset_count_hit,
   input wire logic spec_count_hit,
   input wire logic [15:0] run_time_total,
   input wire logic [15:0] run_time_preset,
   // Reference adjust, rate in 0.01 Hz/s.
   input wire logic [1:0] freq_increment_decrement_inputs,
   input wire logic [15:0] updn_rate,
   // Two-wire terminal control.
   input wire logic two_wire_mode,
   input wire logic [1:0] direction_run_inputs,
   input wire logic lockout_stop_evt,
   // Measured quantities and analog selection.
   input wire logic [MEAS_N-1:0][MEAS_W-1:0] meas,
   input wire logic [ASEL_W-1:0] sel_ao_a,
   input wire logic [ASEL_W-1:0] sel_ao_b,
   input wire logic [ASEL_W-1:0] sel_pulse,
   input wire logic [15:0] max_pulse_hz,
   // Outputs.
   output logic collector_output_a,
   output logic collector_output_b,
   output logic relay_output,
   output logic power_off_display,
   output logic [MEAS_W-1:0] analog_output_a,
   output logic [MEAS_W-1:0] analog_output_b,
   output logic pulse_output,
   output logic [FREQ_W-1:0] ref_freq,
   output logic run_request,
   output logic run_reverse
);

   if (PLC_CYC < 1 || MS_TICK_CYC < 1 || RATE_DIV < 2) begin : g_chk
      $error("timing parameters too small");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Picks one status bit; codes above the table read as inactive.
   function automatic logic pick_status(input logic [SEL_W-1:0] sel,
                                        input logic [SEL_HOST-1:0] vec,
                                        input logic host);
      logic r;
      r = 1'b0;
      if (sel == SEL_HOST) begin
         r = host;
      end else if (sel < SEL_HOST) begin
         r = vec[sel];
      end
      return r;
   endfunction : pick_status

   // Picks one measured quantity; codes above the table read as zero.
   function automatic logic [MEAS_W-1:0] pick_meas(input logic [ASEL_W-1:0] sel,
                                                   input logic [MEAS_N-1:0][MEAS_W-1:0] m);
      logic [MEAS_W-1:0] r;
      r = '0;
      if (sel <= ASEL_MAX) begin
         r = m[sel];
      end
      return r;
   endfunction : pick_meas

   ////////////////////////////////////////////////////////////////////////////
   // Frequency conditions.

   logic frequency_arrival_r;
   logic upper_freq_limit_hit_r;
   logic lower_freq_limit_hit_r;
   logic [FREQ_W-1:0] fdiff;

   assign fdiff = (out_freq > preset_freq) ? out_freq - preset_freq : preset_freq - out_freq;

   // Arrival and limit flags follow their conditions with no memory.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         frequency_arrival_r <= 1'b0;
         upper_freq_limit_hit_r <= 1'b0;
         lower_freq_limit_hit_r <= 1'b0;
      end else begin
         frequency_arrival_r <= (fdiff <= far_band);
         upper_freq_limit_hit_r <= (preset_freq > upper_limit) && (out_freq >= upper_limit);
         lower_freq_limit_hit_r <= (preset_freq < lower_limit) && (out_freq <= lower_limit);
      end
   end

   dsos_cmp_if #(.FW(FREQ_W)) freq_threshold_one_c ();
   dsos_cmp_if #(.FW(FREQ_W)) freq_threshold_two_c ();
   logic freq_threshold_one;
   logic freq_threshold_two;

   // Both thresholds watch the output frequency.
   assign freq_threshold_one_c.freq = out_freq;
   assign freq_threshold_one_c.level = freq_threshold_one_level;
   assign freq_threshold_one_c.lag = freq_threshold_one_lag;
   assign freq_threshold_two_c.freq = out_freq;
   assign freq_threshold_two_c.level = freq_threshold_two_level;
   assign freq_threshold_two_c.lag = freq_threshold_two_lag;
   assign freq_threshold_one = freq_threshold_one_c.hit;
   assign freq_threshold_two = freq_threshold_two_c.hit;

   dsos_hyst u_freq_threshold_one (.clk_sys(clk_sys), .resetn(resetn), .c(freq_threshold_one_c));
   dsos_hyst u_freq_threshold_two (.clk_sys(clk_sys), .resetn(resetn), .c(freq_threshold_two_c));

   ////////////////////////////////////////////////////////////////////////////
   // Overload timing in milliseconds.

   localparam int MSW = $clog2(MS_TICK_CYC + 1);
   logic [MSW-1:0] ms_cnt_r;
   logic [15:0] ol_ms_r;
   logic overload_flag_r;
   logic ms_tick;
   logic over_cur;

   assign ms_tick = (ms_cnt_r == MSW'(MS_TICK_CYC - 1));
   assign over_cur = (out_current > overload_level);

   // Free-running millisecond divider.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ms_cnt_r <= '0;
      end else if (ms_tick) begin
         ms_cnt_r <= '0;
      end else begin
         ms_cnt_r <= ms_cnt_r + 1'b1;
      end
   end

   // Time over threshold restarts whenever current drops back, so short spikes never flag.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ol_ms_r <= '0;
      end else if (!over_cur) begin
         ol_ms_r <= '0;
      end else if (ms_tick && ol_ms_r != 16'hFFFF) begin
         ol_ms_r <= ol_ms_r + 1'b1;
      end
   end

   // Flag needs strictly longer than the set time.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         overload_flag_r <= 1'b0;
      end else begin
         overload_flag_r <= over_cur && (ol_ms_r > overload_ms);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLC completion pulses.

   logic plc_stage_pulse;
   logic plc_cycle_pulse;

   dsos_pulse #(.CYC(PLC_CYC)) u_stage (
      .clk_sys(clk_sys), .resetn(resetn), .ev(plc_stage_done), .pulse(plc_stage_pulse));
   dsos_pulse #(.CYC(PLC_CYC)) u_cycle (
      .clk_sys(clk_sys), .resetn(resetn), .ev(plc_cycle_done), .pulse(plc_cycle_pulse));

   ////////////////////////////////////////////////////////////////////////////
   // Status vector and output selection.

   logic [SEL_HOST-1:0] status_vec;
   logic undervoltage_lockout;
   logic external_fault_code;
   logic drive_ready;

   assign undervoltage_lockout = bus_voltage_low;
   assign external_fault_code = external_fault_trip;
   assign drive_ready = !fault_any && !bus_voltage_low && !stop_cmd_active;

   // One entry per selector code below the host code.
   always_comb begin
      status_vec = '0;
      status_vec[SEL_RUN] = drive_running;
      status_vec[SEL_FAR] = frequency_arrival_r;
      status_vec[SEL_FREQ_THRESHOLD_ONE] = freq_threshold_one;
      status_vec[SEL_FREQ_THRESHOLD_TWO] = freq_threshold_two;
      status_vec[SEL_OVLD] = overload_flag_r;
      status_vec[SEL_UVLO] = undervoltage_lockout;
      status_vec[SEL_EXTF] = external_fault_code;
      status_vec[SEL_FHI] = upper_freq_limit_hit_r;
      status_vec[SEL_FLO] = lower_freq_limit_hit_r;
      status_vec[SEL_ZERO] = drive_running && (out_freq == '0);
      status_vec[SEL_STAGE] = plc_stage_pulse;
      status_vec[SEL_CYCLE] = plc_cycle_pulse;
      status_vec[SEL_PCNT] = preset_count_hit;
      status_vec[SEL_SCNT] = spec_count_hit;
      status_vec[SEL_TIME] = (run_time_total >= run_time_preset);
      status_vec[SEL_RDY] = drive_ready;
      status_vec[SEL_FAIL] = fault_any;
   end

   // Each output decodes its own selector, so one function may feed several pins.
   // Every level is re-evaluated each cycle, so it follows its selected status bit one cycle later.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         collector_output_a <= 1'b0;
         collector_output_b <= 1'b0;
         relay_output <= 1'b0;
         power_off_display <= 1'b0;
      end else begin
         collector_output_a <= pick_status(sel_col_a, status_vec, host_col_a);
         collector_output_b <= pick_status(sel_col_b, status_vec, host_col_b);
         relay_output <= pick_status(sel_relay, status_vec, host_relay);
         power_off_display <= undervoltage_lockout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference frequency ramp from the up/down inputs.

   localparam int RW = $clog2(RATE_DIV) + 2;
   logic [RW-1:0] rate_acc_r;
   logic [RW-1:0] rate_sum;
   logic step;
   logic ud_up;
   logic ud_dn;

   assign ud_up = freq_increment_decrement_inputs[UD_UP] && !freq_increment_decrement_inputs[UD_DN];
   assign ud_dn = freq_increment_decrement_inputs[UD_DN] && !freq_increment_decrement_inputs[UD_UP];
   assign rate_sum = rate_acc_r + RW'(updn_rate);
   assign step = (rate_sum >= RW'(RATE_DIV));

   // Rate accumulates per clock; one 0.01 Hz step each time a second's worth builds up.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rate_acc_r <= '0;
      end else if (!(ud_up || ud_dn)) begin
         rate_acc_r <= '0;
      end else if (step) begin
         rate_acc_r <= rate_sum - RW'(RATE_DIV);
      end else begin
         rate_acc_r <= rate_sum;
      end
   end

   // Up steps stop at the upper limit and down steps stop at the lower limit.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ref_freq <= '0;
      end else if (step && ud_up && ref_freq < upper_limit) begin
         ref_freq <= ref_freq + 1'b1;
      end else if (step && ud_dn && ref_freq > lower_limit) begin
         ref_freq <= ref_freq - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-wire restart interlock.

   logic lockout_r;
   logic lockout_nxt;
   logic dir_held;

   assign dir_held = |direction_run_inputs;

   // A lockout stop while a direction is held blocks restart; set wins over release.
   always_comb begin
      lockout_nxt = lockout_r;
      if (two_wire_mode && lockout_stop_evt && dir_held) begin
         lockout_nxt = 1'b1;
      end else if (!dir_held) begin
         lockout_nxt = 1'b0;
      end
   end

   // A fault never sets the lockout, so clearing the fault restarts a held direction.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lockout_r <= 1'b0;
         run_request <= 1'b0;
         run_reverse <= 1'b0;
      end else begin
         lockout_r <= lockout_nxt;
         run_request <= two_wire_mode && dir_held && !lockout_nxt && !fault_any;
         run_reverse <= (direction_run_inputs == 2'b10);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog and pulse outputs.

   logic [47:0] phase_r;
   logic [47:0] phase_sum;
   logic [MEAS_W-1:0] pulse_meas;

   assign pulse_meas = pick_meas(sel_pulse, meas);
   assign phase_sum = phase_r + 48'(pulse_meas * max_pulse_hz);

   // Analog words pass full scale straight through; 65535 is the top of range.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         analog_output_a <= '0;
         analog_output_b <= '0;
      end else begin
         analog_output_a <= pick_meas(sel_ao_a, meas);
         analog_output_b <= pick_meas(sel_ao_b, meas);
      end
   end

   // Phase accumulator: output rate is quantity over full scale times the maximum rate.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase_r <= '0;
         pulse_output <= 1'b0;
      end else if (phase_sum >= 48'(PULSE_HALF)) begin
         phase_r <= phase_sum - 48'(PULSE_HALF);
         pulse_output <= !pulse_output;
      end else begin
         phase_r <= phase_sum;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   run_select_a: assert property ((sel_col_a == SEL_RUN) |=> collector_output_a == $past(drive_running))
      else $error("run output wrong");
   host_select_a: assert property ((sel_relay == SEL_HOST) |=> relay_output == $past(host_relay))
      else $error("relay host level wrong");
   fail_select_a: assert property ((sel_col_b == SEL_FAIL && fault_any) |=> collector_output_b)
      else $error("fault output missing");
   ready_select_a: assert property ((sel_col_b == SEL_RDY && stop_cmd_active) |=> !collector_output_b)
      else $error("ready shown under stop");
   undervolt_disp_a: assert property (bus_voltage_low |=> power_off_display)
      else $error("power-off display missing");
   arrive_band_a: assert property ((fdiff <= far_band) |=> frequency_arrival_r)
      else $error("arrival flag missing");
   upper_limit_a: assert property ((preset_freq <= upper_limit) |=> !upper_freq_limit_hit_r)
      else $error("upper limit flag wrong");
   lower_limit_a: assert property ((preset_freq >= lower_limit) |=> !lower_freq_limit_hit_r)
      else $error("lower limit flag wrong");
   overload_gate_a: assert property (!over_cur |=> !overload_flag_r ##1 !overload_flag_r [*1])
      else $error("overload without current");
   ref_step_a: assert property (ref_freq != $past(ref_freq) |-> $past(step))
      else $error("reference moved without step");
   restart_lock_a: assert property ((two_wire_mode && lockout_stop_evt && dir_held) |=> !run_request)
      else $error("restart after lockout stop");
   fault_restart_a: assert property ((two_wire_mode && dir_held && !lockout_r && !fault_any
      && !lockout_stop_evt) |=> run_request) else $error("no restart after fault");

   stage_pulse_c: cover property (plc_stage_done ##2 (sel_col_a == SEL_STAGE && collector_output_a));
   fdt_hit_c: cover property ($rose(freq_threshold_one));
   lockout_c: cover property (lockout_r ##1 !dir_held ##[1:4] run_request);
   pulse_tog_c: cover property ($rose(pulse_output));

endmodule : dsos_top
